// ==== src/dac_serial_word_decoder.sv ====
// Purpose: serial load interface and register decoder of a multi-channel DAC
// Assumes: serial pins are asynchronous to clk_i and much slower than it
// Notes: all pin inputs pass two flip-flops before use
// Notes on behaviour
// - route bits 00 system control, 01 channel control, 1x data registers.
// - while frame sync is low, sample data on each of the first sixteen serial clock falls.
// - system control writes ignore the address bits.
// - one channel control register per DAC; only the addressed one updates.
// - bit 13 set means a data write whatever bit 14 holds.
// - bit 15 zero targets main data, one targets sub data.
// - each channel holds a 10-bit main and an 8-bit sub data register.
// - main word: selector, don't care, one, address 12:10, code 9:0.
// - sub word carries its code in bits 9:2; bits 1:0 ignored.
// - channel word: address, bias select 9:8, standby_n bit 4, clear bit 3.
// - system word: coding bit 6, power_down_n 5, standby 4, clear 3.
// - octal decodes the top address bit; quad ignores it.
// - load strobe fall copies all sub data, and main data of channels not under soft clear, to their DAC registers together.
// - hardware clear resets main and sub data and DAC registers everywhere.
// - after hardware clear main is lowest code or midscale per coding.
// - after hardware clear sub sits at its zero-contribution code.
// - software clears touch only main DAC registers, never sub contents.
// - coding select zero is twos complement, one is offset binary.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_word_decoder
    import dac_word_pkg::*;
#(
    parameter bit OCTAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // serial pins
    input wire logic frame_sync_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_in_i,
    // strobe pins
    input wire logic load_strobe_n_i,
    input wire logic clear_request_n_i,
    // system control state
    output logic coding_select_o,
    output logic power_down_n_o,
    output logic global_standby_o,
    output logic global_soft_clear_o,
    // channel control state
    output bias_sel_t [NUM_CH-1:0] bias_select_o,
    output logic [NUM_CH-1:0] channel_standby_n_o,
    output logic [NUM_CH-1:0] channel_clear_o,
    // DAC registers
    output main_code_t [NUM_CH-1:0] main_dac_o,
    output sub_code_t [NUM_CH-1:0] sub_dac_o,
    // word status
    output logic word_commit_o
);
    // map a received address onto a channel index
    function automatic logic [2:0] chan_index(input logic [2:0] addr, input bit octal);
        chan_index = octal ? addr : {1'b0, addr[1:0]};
    endfunction : chan_index

    // main clear code for the selected coding
    function automatic main_code_t main_clear_code(input logic coding);
        main_clear_code = (coding == CODING_OFFSET) ? MAIN_CLEAR_OFFSET : MAIN_CLEAR_TWOS;
    endfunction : main_clear_code

    // sub code that adds nothing to the main output
    function automatic sub_code_t sub_zero_code(input logic coding);
        sub_zero_code = (coding == CODING_OFFSET) ? SUB_ZERO_OFFSET : SUB_ZERO_TWOS;
    endfunction : sub_zero_code

    // synchronised pins
    logic fs_level;
    logic sclk_fall;
    logic serial_data_in_level;
    logic load_strobe_n_fall;
    logic clr_level;

    pin_sync_edge #(.RST_LEVEL(1'b1)) u_sync_fs (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(frame_sync_n_i),
        .level_o(fs_level),
        .fall_o()
    );

    pin_sync_edge #(.RST_LEVEL(1'b1)) u_sync_sclk (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(serial_clock_i),
        .level_o(),
        .fall_o(sclk_fall)
    );

    pin_sync_edge #(.RST_LEVEL(1'b0)) u_sync_serial_data_in (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(serial_data_in_i),
        .level_o(serial_data_in_level),
        .fall_o()
    );

    pin_sync_edge #(.RST_LEVEL(1'b1)) u_sync_load_strobe_n (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(load_strobe_n_i),
        .level_o(),
        .fall_o(load_strobe_n_fall)
    );

    pin_sync_edge #(.RST_LEVEL(1'b1)) u_sync_clr (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(clear_request_n_i),
        .level_o(clr_level),
        .fall_o()
    );

    // input shift register
    logic [4:0] bit_count;
    logic [WORD_BITS-1:0] shift;
    logic [WORD_BITS-1:0] word;
    logic commit;

    wire fs_low = ~fs_level;
    wire take_bit = sclk_fall & fs_low & (bit_count < BIT_COUNT_FULL);
    wire [WORD_BITS-1:0] next_shift = {shift[WORD_BITS-2:0], serial_data_in_level};
    wire last_bit = take_bit & (bit_count == BIT_COUNT_LAST);
    wire [4:0] next_count = bit_count + 5'h01;

    always_ff @(posedge clk_i) begin
        if (!rstn_i || !fs_low) begin
            bit_count <= 5'h00;
        end else if (take_bit) begin
            bit_count <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            shift <= 16'h0000;
        end else if (take_bit) begin
            shift <= next_shift;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            word <= 16'h0000;
            commit <= 1'b0;
        end else begin
            commit <= last_bit;
            if (last_bit) begin
                word <= next_shift;
            end
        end
    end

    // word decode
    wire is_data = word[POS_ROUTE_HIGH];
    wire is_chan = ~word[POS_ROUTE_HIGH] & word[POS_ROUTE_LOW];
    wire is_sys = ~word[POS_ROUTE_HIGH] & ~word[POS_ROUTE_LOW];
    wire [2:0] addr = {word[POS_ADDR_TOP], word[POS_ADDR_MID], word[POS_ADDR_LOW]};
    wire [2:0] ch = chan_index(addr, OCTAL);
    wire wr_sys = commit & is_sys;
    wire wr_chan = commit & is_chan;
    wire wr_main = commit & is_data & ~word[POS_MAIN_SUB];
    wire wr_sub = commit & is_data & word[POS_MAIN_SUB];
    wire main_code_t word_main = word[POS_MAIN_HI:POS_MAIN_LO];
    wire sub_code_t word_sub = word[POS_SUB_HI:POS_SUB_LO];
    wire bias_sel_t word_bias = word[POS_BIAS_HIGH:POS_BIAS_LOW];
    wire hw_clear = ~clr_level;
    wire sys_clear_write = wr_sys & word[POS_GLB_CLEAR];

    // system control register
    logic coding;
    logic power_down_n;
    logic glb_standby;
    logic glb_clear;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            coding <= RST_CODING;
            power_down_n <= RST_POWER_DOWN_N;
            glb_standby <= RST_GLB_STANDBY;
            glb_clear <= RST_GLB_CLEAR;
        end else if (wr_sys) begin
            coding <= word[POS_CODING];
            power_down_n <= word[POS_POWER_DOWN_N];
            glb_standby <= word[POS_GLB_STANDBY];
            glb_clear <= word[POS_GLB_CLEAR];
        end
    end

    wire main_code_t clear_main = main_clear_code(coding);
    wire sub_code_t zero_sub = sub_zero_code(coding);

    // per-channel control registers
    bias_sel_t bias_sel [NUM_CH];
    logic ch_standby_n [NUM_CH];
    logic ch_clear [NUM_CH];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                bias_sel[i] <= RST_BIAS;
                ch_standby_n[i] <= RST_CH_STANDBY_N;
                ch_clear[i] <= RST_CH_CLEAR;
            end
        end else if (wr_chan) begin
            bias_sel[ch] <= word_bias;
            ch_standby_n[ch] <= word[POS_CH_STANDBY_N];
            ch_clear[ch] <= word[POS_CH_CLEAR];
        end
    end

    // data registers
    main_code_t main_data [NUM_CH];
    sub_code_t sub_data [NUM_CH];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                main_data[i] <= MAIN_CLEAR_TWOS;
                sub_data[i] <= SUB_ZERO_TWOS;
            end
        end else if (hw_clear) begin
            for (int i = 0; i < NUM_CH; i++) begin
                main_data[i] <= clear_main;
                sub_data[i] <= zero_sub;
            end
        end else begin
            if (wr_main) begin
                main_data[ch] <= word_main;
            end
            if (wr_sub) begin
                sub_data[ch] <= word_sub;
            end
        end
    end

    // DAC registers
    main_code_t main_dac [NUM_CH];
    sub_code_t sub_dac [NUM_CH];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                main_dac[i] <= MAIN_CLEAR_TWOS;
                sub_dac[i] <= SUB_ZERO_TWOS;
            end
        end else if (hw_clear) begin
            for (int i = 0; i < NUM_CH; i++) begin
                main_dac[i] <= clear_main;
                sub_dac[i] <= zero_sub;
            end
        end else if (load_strobe_n_fall) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (glb_clear || ch_clear[i] || sys_clear_write) begin
                    main_dac[i] <= clear_main;
                end else begin
                    main_dac[i] <= main_data[i];
                end
                sub_dac[i] <= sub_data[i];
            end
        end else if (sys_clear_write) begin
            for (int i = 0; i < NUM_CH; i++) begin
                main_dac[i] <= clear_main;
            end
        end
    end

    // outputs
    assign coding_select_o = coding;
    assign power_down_n_o = power_down_n;
    assign global_standby_o = glb_standby;
    assign global_soft_clear_o = glb_clear;
    assign word_commit_o = commit;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            bias_select_o[i] = bias_sel[i];
            channel_standby_n_o[i] = ch_standby_n[i];
            channel_clear_o[i] = ch_clear[i];
            main_dac_o[i] = main_dac[i];
            sub_dac_o[i] = sub_dac[i];
        end
    end
endmodule : dac_serial_word_decoder
`default_nettype wire

// ==== pkg/dac_word_pkg.sv ====
// Purpose: shared constants and types for the serial word decoder
// Assumes: 16-bit words, up to eight channels
// Notes: bit positions are positions within the received word
package dac_word_pkg;
    // word framing
    localparam int WORD_BITS = 16;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
    localparam logic [4:0] BIT_COUNT_LAST = 5'h0F;
    localparam int NUM_CH = 8;

    // routing and address fields
    localparam int POS_MAIN_SUB = 15;
    localparam int POS_ROUTE_LOW = 14;
    localparam int POS_ROUTE_HIGH = 13;
    localparam int POS_ADDR_TOP = 12;
    localparam int POS_ADDR_MID = 11;
    localparam int POS_ADDR_LOW = 10;

    // data fields
    localparam int POS_MAIN_HI = 9;
    localparam int POS_MAIN_LO = 0;
    localparam int POS_SUB_HI = 9;
    localparam int POS_SUB_LO = 2;

    // channel control fields
    localparam int POS_BIAS_HIGH = 9;
    localparam int POS_BIAS_LOW = 8;
    localparam int POS_CH_STANDBY_N = 4;
    localparam int POS_CH_CLEAR = 3;

    // system control fields
    localparam int POS_CODING = 6;
    localparam int POS_POWER_DOWN_N = 5;
    localparam int POS_GLB_STANDBY = 4;
    localparam int POS_GLB_CLEAR = 3;

    // coding select values
    localparam logic CODING_TWOS = 1'b0;
    localparam logic CODING_OFFSET = 1'b1;

    typedef logic [9:0] main_code_t;
    typedef logic [7:0] sub_code_t;
    typedef logic [1:0] bias_sel_t;

    // clear codes
    localparam main_code_t MAIN_CLEAR_OFFSET = 10'h000;
    localparam main_code_t MAIN_CLEAR_TWOS = 10'h000;
    localparam sub_code_t SUB_ZERO_OFFSET = 8'h80;
    localparam sub_code_t SUB_ZERO_TWOS = 8'h00;

    // reset values
    localparam logic RST_CODING = 1'b0;
    localparam logic RST_POWER_DOWN_N = 1'b1;
    localparam logic RST_GLB_STANDBY = 1'b0;
    localparam logic RST_GLB_CLEAR = 1'b0;
    localparam bias_sel_t RST_BIAS = 2'h0;
    localparam logic RST_CH_STANDBY_N = 1'b1;
    localparam logic RST_CH_CLEAR = 1'b0;
endpackage : dac_word_pkg

// ==== src/pin_sync_edge.sv ====
// Purpose: two-stage synchroniser with falling-edge detect
// Assumes: async_i comes from outside the clk_i domain
// Notes: reset level chosen per instance
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
    parameter logic RST_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // pin side
    input wire logic async_i,
    // synchronised side
    output logic level_o,
    output logic fall_o
);
    logic meta;
    logic stable;
    logic prev;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta <= RST_LEVEL;
            stable <= RST_LEVEL;
            prev <= RST_LEVEL;
        end else begin
            meta <= async_i;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level_o = stable;
    assign fall_o = prev & ~stable;
endmodule : pin_sync_edge
`default_nettype wire

// ==== sim/host_model.sv ====
// Purpose: serial host model for the word decoder
// Assumes: 80 ns serial clock, idle high between frames
// Notes: released data line shows the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // serial pins
    output logic frame_sync_n_o,
    output logic serial_clock_o,
    output logic serial_data_o
);
    initial begin
        frame_sync_n_o = 1'b1;
        serial_clock_o = 1'b1;
        serial_data_o = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int n);
        frame_sync_n_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_data_o = w[i];
            #40 serial_clock_o = 1'b0;
            #40 serial_clock_o = 1'b1;
        end
        #40 frame_sync_n_o = 1'b1;
        serial_data_o = ~serial_data_o;
        #200;
    endtask : send
endmodule : host_model
`default_nettype wire

// ==== sim/dac_word_checker.sv ====
// Purpose: port assertions for the serial word decoder
// Assumes: pins change well away from clk_i edges
// Notes: pin history registers give the windows of cause
`timescale 1ns/1ps
`default_nettype none
module dac_word_checker
    import dac_word_pkg::*;
(
    // clock, reset and pins
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic frame_sync_n_i,
    input wire logic serial_clock_i,
    input wire logic load_strobe_n_i,
    input wire logic clear_request_n_i,
    // watched outputs
    input wire logic coding_select_o,
    input wire logic power_down_n_o,
    input wire logic global_standby_o,
    input wire logic global_soft_clear_o,
    input wire bias_sel_t [NUM_CH-1:0] bias_select_o,
    input wire logic [NUM_CH-1:0] channel_standby_n_o,
    input wire logic [NUM_CH-1:0] channel_clear_o,
    input wire main_code_t [NUM_CH-1:0] main_dac_o,
    input wire sub_code_t [NUM_CH-1:0] sub_dac_o,
    input wire logic word_commit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [4:0] falls;
    logic [5:0] ld_h;
    logic [5:0] cl_h;
    logic sck_q;
    logic ld_q;
    logic fs_q;
    wire sck_fall = sck_q & !serial_clock_i & !frame_sync_n_i;
    always_ff @(posedge clk_i) begin
        sck_q <= serial_clock_i;
        ld_q <= load_strobe_n_i;
        fs_q <= frame_sync_n_i;
        ld_h <= {ld_h[4:0], ld_q & !load_strobe_n_i};
        cl_h <= {cl_h[4:0], !clear_request_n_i};
        if (fs_q && !frame_sync_n_i) falls <= 5'h00;
        else if (sck_fall && falls != 5'h1F) falls <= falls + 5'h01;
    end
    sequence hw_clear_held;
        !clear_request_n_i [*4];
    endsequence
    chk_commit_single: assert property (word_commit_o |=> !word_commit_o)
        else $error("commit pulse too long");
    chk_commit_count: assert property (word_commit_o |-> falls == 5'h10)
        else $error("commit without sixteen clock falls");
    chk_hw_main: assert property (hw_clear_held |->
        main_dac_o == {NUM_CH{coding_select_o ? MAIN_CLEAR_OFFSET : MAIN_CLEAR_TWOS}})
        else $error("main not cleared by hardware clear");
    chk_hw_sub: assert property (hw_clear_held |->
        sub_dac_o == {NUM_CH{coding_select_o ? SUB_ZERO_OFFSET : SUB_ZERO_TWOS}})
        else $error("sub not at zero code in hardware clear");
    chk_sub_cause: assert property ($changed(sub_dac_o) |-> (|ld_h) || (|cl_h))
        else $error("sub changed without load or clear");
    chk_main_cause: assert property ($changed(main_dac_o) |->
        (|ld_h) || (|cl_h) || $past(word_commit_o))
        else $error("main changed without cause");
    chk_ctrl_commit: assert property ($changed({coding_select_o, power_down_n_o,
        global_standby_o, global_soft_clear_o, bias_select_o, channel_standby_n_o,
        channel_clear_o}) |-> $past(word_commit_o))
        else $error("control changed without commit");
    chk_one_channel: assert property ($onehot0(
        channel_standby_n_o ^ $past(channel_standby_n_o)))
        else $error("several channels changed");
endmodule : dac_word_checker
bind dac_serial_word_decoder dac_word_checker u_chk (.*);
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the serial word decoder
// Assumes: octal and quad builds side by side, host model drives the serial pins
// Notes: expectations kept in shadow arrays
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dac_word_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ld_n = 1'b1;
    logic clr_n = 1'b1;
    wire fs_n;
    wire sck;
    wire sdi;
    logic cod, pdn, gsb, gsc, cmt;
    bias_sel_t [NUM_CH-1:0] bias;
    logic [NUM_CH-1:0] csb, ccl;
    main_code_t [NUM_CH-1:0] md, em, mdat, qmd;
    sub_code_t [NUM_CH-1:0] sdac, es, sdat;
    int err_count = 0;
    int checks = 0;
    int commits = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (cmt === 1'b1) commits++;
    host_model u_host (.frame_sync_n_o(fs_n), .serial_clock_o(sck), .serial_data_o(sdi));
    dac_serial_word_decoder u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .frame_sync_n_i(fs_n),
        .serial_clock_i(sck), .serial_data_in_i(sdi), .load_strobe_n_i(ld_n),
        .clear_request_n_i(clr_n), .coding_select_o(cod), .power_down_n_o(pdn),
        .global_standby_o(gsb), .global_soft_clear_o(gsc), .bias_select_o(bias),
        .channel_standby_n_o(csb), .channel_clear_o(ccl), .main_dac_o(md),
        .sub_dac_o(sdac), .word_commit_o(cmt));
    dac_serial_word_decoder #(.OCTAL(1'b0)) u_quad (.clk_i(clk_i), .rstn_i(rstn_i),
        .frame_sync_n_i(fs_n), .serial_clock_i(sck), .serial_data_in_i(sdi),
        .load_strobe_n_i(ld_n), .clear_request_n_i(clr_n), .coding_select_o(),
        .power_down_n_o(), .global_standby_o(), .global_soft_clear_o(), .bias_select_o(),
        .channel_standby_n_o(), .channel_clear_o(), .main_dac_o(qmd), .sub_dac_o(),
        .word_commit_o());
    task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic wr(input logic [15:0] w, input int n = 16);
        int c;
        c = commits;
        u_host.send(w, n);
        chk("commits", (n == 16) ? 1 : 0, commits - c);
    endtask : wr
    task automatic pulse(input bit ld);
        @(negedge clk_i);
        if (ld) ld_n = 1'b0;
        else clr_n = 1'b0;
        repeat (6) @(negedge clk_i);
        ld_n = 1'b1;
        clr_n = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask : pulse
    task automatic cmp_dac();
        chk("main", em, md);
        chk("sub", es, sdac);
    endtask : cmp_dac
    task automatic t_data();
        for (int i = 0; i < NUM_CH; i++) begin
            mdat[i] = 10'h2A5 ^ 10'(i);
            sdat[i] = 8'h3C ^ 8'(i * 17);
            wr({1'b0, i[0], 1'b1, i[2:0], mdat[i]});
            wr({1'b1, i[1], 1'b1, i[2:0], sdat[i], 2'(i)});
        end
        cmp_dac();
        pulse(1'b1);
        em = mdat;
        es = sdat;
        cmp_dac();
        chk("quad main", {40'h0, mdat[7:4]}, qmd);
    endtask : t_data
    task automatic t_chan();
        wr({3'h6, 3'h5, 2'h2, 3'h0, 1'b0, 1'b0, 3'h3});
        chk("bias", 16'h0800, bias);
        chk("standby", 8'hDF, csb);
    endtask : t_chan
    task automatic t_sys();
        wr({6'h27, 3'h0, 4'hA, 3'h3});
        chk("system", 4'hA, {cod, pdn, gsb, gsc});
        chk("bias", 16'h0800, bias);
        wr({6'h27, 3'h0, 4'hB, 3'h3});
        chk("system", 4'hB, {cod, pdn, gsb, gsc});
        em = '0;
        cmp_dac();
        wr({6'h27, 3'h0, 4'hC, 3'h3});
        chk("system", 4'hC, {cod, pdn, gsb, gsc});
        pulse(1'b1);
        em = mdat;
        cmp_dac();
    endtask : t_sys
    task automatic t_chclr();
        wr({3'h6, 3'h2, 2'h1, 3'h0, 1'b1, 1'b1, 3'h0});
        chk("chclear", 8'h04, ccl);
        cmp_dac();
        pulse(1'b1);
        em[2] = '0;
        cmp_dac();
        wr({3'h6, 3'h2, 2'h1, 3'h0, 1'b1, 1'b0, 3'h0});
        pulse(1'b1);
        em = mdat;
        cmp_dac();
    endtask : t_chclr
    initial begin
        #500000;
        err_count++;
        close_out();
    end
    task automatic t_reset();
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk("system", 4'h4, {cod, pdn, gsb, gsc});
        chk("standby", 8'hFF, csb);
        em = '0;
        es = '0;
        cmp_dac();
    endtask : t_reset
    task automatic t_hwclr();
        pulse(1'b0);
        em = '0;
        es = {NUM_CH{SUB_ZERO_OFFSET}};
        cmp_dac();
        pulse(1'b1);
        cmp_dac();
        wr({6'h27, 3'h0, 4'h4, 3'h3});
        chk("system", 4'h4, {cod, pdn, gsb, gsc});
        pulse(1'b0);
        es = {NUM_CH{SUB_ZERO_TWOS}};
        cmp_dac();
    endtask : t_hwclr
    initial begin
        t_reset();
        t_data();
        wr(16'h2000, 8);
        t_chan();
        t_sys();
        t_chclr();
        t_hwclr();
        close_out();
    end
endmodule : tb
`default_nettype wire
